// *** core/eeprom_link_pkg.sv ***
/*
 * shared constants for the two-wire memory link: slave address group,
 * memory geometry, bus timing and master command codes.
 * assumes a 20 MHz system clock on both ends.
 */
`default_nettype none

package eeprom_link_pkg;

   // system clock period
   localparam int SYS_CLK_NS = 50;

   // memory geometry: 16 rows of 8 bytes
   localparam int MEM_BYTES = 128;
   localparam int ROW_BYTES = 8;
   localparam int ADDR_W = 7;
   localparam int COL_W = 3;
   localparam int ROW_W = 4;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // fixed upper slave address bits
   localparam logic [3:0] SLAVE_GROUP = 4'ha;

   // bus bit period made by the master, and its quarter in cycles
   localparam int SCL_PERIOD_NS = 10000;
   localparam int QUARTER_CYC = (SCL_PERIOD_NS / 4 + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int QCNT_W = 8;

   // longest program cycle time, rounded down to cycles
   localparam int PROGRAM_CYCLE_TIME_US = 10000;
   localparam int PROG_CYC = PROGRAM_CYCLE_TIME_US * 1000 / SYS_CLK_NS;
   localparam int PROG_W = 18;

   // bit counts
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // master command kinds
   typedef enum logic [1:0] {
      CMD_START,
      CMD_WRITE,
      CMD_READ,
      CMD_STOP
   } cmd_kind_t;

   // command word: kind, data byte, more-to-read flag
   localparam int CMD_W = 11;
   localparam int FIFO_DEPTH = 16;

endpackage

`default_nettype wire

// *** core/eeprom_slave.sv ***
/*
 * memory end of the two-wire link: 128-byte array behind a slave that
 * decodes start/stop, matches its address, loads a word pointer, fills
 * an 8-byte row buffer and programs it at stop, and streams reads.
 * assumes bus lines and select pins are asynchronous to sys_clk and that
 * scl stays well below a quarter of the system clock rate.
 */
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// R1: master starts transfers only on idle bus
// R2: sda change while scl high is control
// R3: both lines high and released when idle
// R4: sda fall, scl high: start, restart byte
// R5: sda rise, scl high: stop, end transfer
// R6: eight bits then one acknowledge clock
// R7: acknowledge each received byte, sda held low
// R8: master acknowledges each byte it reads
// R9: master ends read with no-ack, then stop
// R10: after no-ack, release sda high
// R11: first byte after start is slave address
// R12: word address then one to eight bytes
// R13: column increments, row stays latched
// R14: program at stop, only complete acked bytes
// R15: ignore own address while programming
// R16: master needs new transfer for next row
// R17: read continues while acked, pointer increments
// R18: wrapped column moves pointer to next row
// R19: master best starts full page at column zero
// R20: address upper bits 1010, rest from pins
// R21: 128 bytes in rows of eight
// R22: address lsb selects write or read
// R23: no match: no ack, wait for start
// R24: byte after address loads word pointer
module eeprom_slave
   import eeprom_link_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // bus side
   two_wire_if.device bus,
   // select straps
   input wire logic hw_select_pin_0,
   input wire logic hw_select_pin_1,
   input wire logic hw_select_pin_2,
   // status
   output logic programming
);

   typedef enum logic [2:0] {
      S_IDLE,
      S_ADDR,
      S_WADDR,
      S_WDATA,
      S_TX,
      S_IGNORE
   } dev_state_t;

   typedef struct packed {
      dev_state_t st;
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic [2:0][2:0] pin_sync;
      logic scl;
      logic sda;
      logic [2:0] hw_sel;
      logic [3:0] bits;
      logic ack_phase;
      logic [7:0] shreg;
      logic [ADDR_W-1:0] word_addr;
      logic [ROW_W-1:0] row;
      logic [ROW_BYTES*8-1:0] page;
      logic [ROW_BYTES-1:0] page_valid;
      logic drive_low;
      logic mack;
      logic busy;
      logic [PROG_W-1:0] timer;
      logic commit;
   } dev_reg_t;

   dev_reg_t s;
   dev_reg_t next_s;
   logic [7:0] mem [MEM_BYTES];
   logic [7:0] rd_byte;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [ADDR_W-1:0] addr_inc;

   // the array is read combinationally at the pointer
   assign rd_byte = mem[s.word_addr];
   assign addr_inc = s.word_addr + 7'h01; // R17 R18

   // pad drivers: the pad only ever pulls low
   assign bus.d_sda_o = 1'b0;
   assign bus.d_sda_oe = s.drive_low;
   assign programming = s.busy;

   // line sampling, condition detection and the transfer sequencer
   always_comb begin
      next_s = s;
      next_s.commit = 1'b0;
      // three-stage sampling; a level counts once stages two and three agree
      next_s.scl_sync = {s.scl_sync[1:0], bus.scl};
      next_s.sda_sync = {s.sda_sync[1:0], bus.sda};
      next_s.pin_sync = {s.pin_sync[1:0],
                         {hw_select_pin_2, hw_select_pin_1, hw_select_pin_0}};
      if (s.scl_sync[2] == s.scl_sync[1]) begin
         next_s.scl = s.scl_sync[2];
      end
      if (s.sda_sync[2] == s.sda_sync[1]) begin
         next_s.sda = s.sda_sync[2];
      end
      if (s.pin_sync[2] == s.pin_sync[1]) begin
         next_s.hw_sel = s.pin_sync[2];
      end
      scl_rise = !s.scl && next_s.scl;
      scl_fall = s.scl && !next_s.scl;
      // sda moving while scl stays high is a bus condition, never data
      start_seen = s.scl && next_s.scl && s.sda && !next_s.sda; // R2 R4
      stop_seen = s.scl && next_s.scl && !s.sda && next_s.sda; // R2 R5

      // program cycle timer
      if (s.busy) begin
         if (s.timer == '0) begin
            next_s.busy = 1'b0;
         end else begin
            next_s.timer = s.timer - 18'h00001;
         end
      end

      if (start_seen) begin
         // a start may come at any point; byte reception restarts cleanly
         next_s.st = S_ADDR; // R4 R11
         next_s.bits = '0;
         next_s.ack_phase = 1'b0;
         next_s.drive_low = 1'b0;
      end else if (stop_seen) begin
         // only bytes already acknowledged sit in the valid mask
         if (s.st == S_WDATA && |s.page_valid) begin
            next_s.commit = 1'b1; // R14
            next_s.busy = 1'b1; // R15
            next_s.timer = PROG_W'(PROG_CYCLES - 1);
         end
         next_s.st = S_IDLE; // R5 R3
         next_s.ack_phase = 1'b0;
         next_s.drive_low = 1'b0;
      end else if (s.st != S_IDLE && s.st != S_IGNORE) begin
         if (scl_rise) begin
            if (s.ack_phase) begin
               next_s.mack = !next_s.sda; // R8
            end else begin
               next_s.bits = s.bits + 4'h1; // R6
               if (s.st != S_TX) begin
                  next_s.shreg = {s.shreg[6:0], next_s.sda};
               end
            end
         end else if (scl_fall) begin
            if (s.ack_phase) begin
               // end of the acknowledge clock
               next_s.ack_phase = 1'b0;
               next_s.bits = '0;
               next_s.drive_low = 1'b0;
               if (s.st == S_TX) begin
                  if (s.mack) begin
                     next_s.drive_low = !rd_byte[7]; // R17
                     next_s.shreg = {rd_byte[6:0], 1'b0};
                     next_s.word_addr = addr_inc;
                  end else begin
                     next_s.st = S_IGNORE; // R9 R10
                  end
               end
            end else if (s.bits == BYTE_BITS) begin
               // byte complete: acknowledge or hand the line to the master
               next_s.ack_phase = 1'b1; // R6
               case (s.st)
                  S_ADDR: begin
                     if (s.shreg[7:1] == {SLAVE_GROUP, s.hw_sel} && !s.busy) begin // R20 R15
                        next_s.drive_low = 1'b1; // R7
                        next_s.mack = 1'b1;
                        next_s.st = s.shreg[0] ? S_TX : S_WADDR; // R22
                     end else begin
                        next_s.ack_phase = 1'b0;
                        next_s.st = S_IGNORE; // R23
                     end
                  end
                  S_WADDR: begin
                     next_s.word_addr = s.shreg[ADDR_W-1:0]; // R24
                     next_s.row = s.shreg[ADDR_W-1:COL_W]; // R13
                     next_s.page_valid = '0;
                     next_s.drive_low = 1'b1; // R7
                     next_s.st = S_WDATA;
                  end
                  S_WDATA: begin
                     // later bytes overwrite earlier ones once the column wraps
                     next_s.page[{s.word_addr[COL_W-1:0], 3'h0} +: 8] = s.shreg; // R12 R13
                     next_s.page_valid[s.word_addr[COL_W-1:0]] = 1'b1; // R14
                     next_s.word_addr = addr_inc; // R13 R18
                     next_s.drive_low = 1'b1; // R7
                  end
                  default: begin
                     // transmitter releases sda for the master's answer
                     next_s.drive_low = 1'b0;
                  end
               endcase
            end else if (s.st == S_TX) begin
               next_s.drive_low = !s.shreg[7];
               next_s.shreg = {s.shreg[6:0], 1'b0};
            end
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.st <= S_IDLE;
         s.scl_sync <= 3'h7;
         s.sda_sync <= 3'h7;
         s.scl <= 1'b1;
         s.sda <= 1'b1;
         s.mack <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // the array starts erased; a commit writes the valid bytes of the latched row at once
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] <= ERASED_BYTE; // R21
         end
      end else if (s.commit) begin
         for (int i = 0; i < ROW_BYTES; i++) begin
            if (s.page_valid[i]) begin
               mem[{s.row, 3'(i)}] <= s.page[i*8 +: 8]; // R14 R13
            end
         end
      end
   end

endmodule

`default_nettype wire

// *** core/two_wire_if.sv ***
/*
 * the two-wire bus between master and memory end.
 * both lines are open drain with pull-ups: a line is low while any
 * party enables its low driver.
 */
`timescale 1ns/1ns
`default_nettype none

interface two_wire_if;
   // master drivers
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   // memory end driver
   logic d_sda_o;
   logic d_sda_oe;
   // resolved line levels
   logic scl;
   logic sda;

   // wired-and with pull-up
   assign scl = !(m_scl_oe && !m_scl_o);
   assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);

   modport master (input scl, input sda, output m_scl_o, output m_scl_oe,
                   output m_sda_o, output m_sda_oe);
   modport device (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

`default_nettype wire

// *** core/two_wire_master.sv ***
/*
 * master end of the two-wire link: a command FIFO feeding a bit engine
 * that makes scl by dividing sys_clk into quarter-bit steps.
 * assumes the user queues START, WRITE/READ bytes and STOP in a legal
 * order; the bus is assumed to have no other master.
 */
`timescale 1ns/1ns
`default_nettype none

module cmd_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
      logic full;
   } fifo_reg_t;

   fifo_reg_t s;
   fifo_reg_t next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // full is kept in a register so in_ready leaves the block straight off a flip-flop
   assign in_ready = !s.full;
   assign out_valid = s.wr != s.rd;
   assign out_data = mem[s.rd[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer update
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.wr = s.wr + 1'b1;
      end
      if (pop) begin
         next_s.rd = s.rd + 1'b1;
      end
      // an extra pointer bit tells full from empty
      next_s.full = next_s.wr[AW] != next_s.rd[AW]
                    && next_s.wr[AW-1:0] == next_s.rd[AW-1:0];
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // storage carries no reset; only pushed words are ever read
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[s.wr[AW-1:0]] <= in_data;
      end
   end
endmodule

module two_wire_master
   import eeprom_link_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // bus side
   two_wire_if.master bus,
   // command stream
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_kind,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_more,
   // answers
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_ack
);

   typedef enum logic [1:0] {
      M_IDLE,
      M_START,
      M_BIT,
      M_STOP
   } mst_state_t;

   typedef struct packed {
      mst_state_t st;
      logic [QCNT_W-1:0] qcnt;
      logic [1:0] step;
      logic [3:0] bitn;
      logic [8:0] tx;
      logic [8:0] rx;
      logic scl_low;
      logic sda_low;
      logic [2:0] sda_sync;
      logic sda_in;
      logic rsp_valid;
      logic [7:0] rsp_data;
      logic rsp_ack;
   } mst_reg_t;

   mst_reg_t s;
   mst_reg_t next_s;
   logic q_valid;
   logic q_ready;
   logic [CMD_W-1:0] q_data;
   logic tick;
   logic [8:0] nrx;

   // back-pressure: commands wait in the queue while the engine is busy
   cmd_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data({cmd_kind, cmd_data, cmd_more}),
      .out_valid(q_valid),
      .out_ready(q_ready),
      .out_data(q_data)
   );

   assign q_ready = s.st == M_IDLE;
   assign bus.m_scl_o = 1'b0;
   assign bus.m_scl_oe = s.scl_low;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_sda_oe = s.sda_low;
   assign rsp_valid = s.rsp_valid;
   assign rsp_data = s.rsp_data;
   assign rsp_ack = s.rsp_ack;

   // quarter-bit stepper; data bits move sda only while scl is low, start and stop move it with scl high
   always_comb begin
      next_s = s;
      next_s.rsp_valid = 1'b0;
      next_s.sda_sync = {s.sda_sync[1:0], bus.sda};
      if (s.sda_sync[2] == s.sda_sync[1]) begin
         next_s.sda_in = s.sda_sync[2];
      end
      tick = s.qcnt == QCNT_W'(QUARTER_CYC - 1);
      next_s.qcnt = tick ? '0 : s.qcnt + 8'h01;
      nrx = {s.rx[7:0], s.sda_in};
      case (s.st)
         M_IDLE: begin
            if (q_valid) begin
               next_s.step = '0;
               next_s.qcnt = '0;
               next_s.bitn = '0;
               case (cmd_kind_t'(q_data[10:9]))
                  CMD_START: next_s.st = M_START; // R1
                  CMD_STOP: next_s.st = M_STOP;
                  CMD_WRITE: begin
                     next_s.st = M_BIT;
                     next_s.tx = {q_data[8:1], 1'b1};
                  end
                  default: begin
                     next_s.st = M_BIT;
                     next_s.tx = {8'hff, !q_data[0]}; // R8 R9
                  end
               endcase
            end
         end
         M_START: begin
            if (tick) begin
               next_s.step = s.step + 2'h1;
               case (s.step)
                  2'h0: next_s.sda_low = 1'b0;
                  2'h1: next_s.scl_low = 1'b0;
                  2'h2: next_s.sda_low = 1'b1; // R4
                  default: begin
                     next_s.scl_low = 1'b1;
                     next_s.st = M_IDLE;
                  end
               endcase
            end
         end
         M_BIT: begin
            if (tick) begin
               next_s.step = s.step + 2'h1;
               case (s.step)
                  2'h0: next_s.sda_low = !s.tx[8]; // R2
                  2'h1: next_s.scl_low = 1'b0;
                  2'h2: next_s.scl_low = 1'b0;
                  default: begin
                     // sample at the end of the high phase, then pull scl low
                     next_s.rx = nrx;
                     next_s.tx = {s.tx[7:0], 1'b1};
                     next_s.scl_low = 1'b1;
                     next_s.bitn = s.bitn + 4'h1;
                     if (s.bitn == BYTE_BITS) begin
                        next_s.st = M_IDLE; // R6
                        next_s.rsp_valid = 1'b1;
                        next_s.rsp_data = nrx[8:1];
                        next_s.rsp_ack = !nrx[0];
                     end
                  end
               endcase
            end
         end
         default: begin
            if (tick) begin
               next_s.step = s.step + 2'h1;
               case (s.step)
                  2'h0: next_s.sda_low = 1'b1;
                  2'h1: next_s.scl_low = 1'b0;
                  2'h2: next_s.sda_low = 1'b0; // R5 R3
                  default: next_s.st = M_IDLE;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.st <= M_IDLE;
         s.sda_sync <= 3'h7;
         s.sda_in <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

endmodule

`default_nettype wire

// *** test/link_properties.sv ***
/*
 * bus checker for the two-wire link between master and memory end.
 * assumes resolved line levels and the memory end's drive enable,
 * all sampled on sys_clk, with nrst asynchronous and active low.
 */
`timescale 1ns/1ns
`default_nettype none

module link_properties (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // bus lines and memory end driver
   input wire logic scl,
   input wire logic sda,
   input wire logic d_sda_oe
);
   logic scl_d;
   logic sda_d;
   logic [3:0] bit_no;
   logic first;
   logic quiet;
   logic rise;
   logic start;
   logic stop;

   // line events as seen by one sample of delay
   assign rise = scl && !scl_d;
   assign start = scl && scl_d && sda_d && !sda;
   assign stop = scl && scl_d && !sda_d && sda;

   // bit position in byte, address phase and ignore-till-start flag
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         bit_no <= 4'h0;
         first <= 1'b1;
         quiet <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
         if (start) begin
            bit_no <= 4'h0;
            first <= 1'b1;
            quiet <= 1'b0;
         end else if (rise) begin
            bit_no <= (bit_no == 4'h8) ? 4'h0 : bit_no + 4'h1;
            if (bit_no == 4'h8) begin
               first <= 1'b0;
               // an unanswered ninth bit silences the memory end till start
               quiet <= quiet | sda;
            end
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_start;
      start;
   endsequence
   sequence s_stop;
      stop;
   endsequence
   sequence s_rise;
      rise;
   endsequence

   property p_dev_moves_low;
      $changed(d_sda_oe) |-> !scl && !scl_d;
   endproperty
   a_dev_moves_low: assert property (p_dev_moves_low)
      else $error("memory end changed sda while scl high");

   property p_bit_stable;
      s_rise |=> $stable(sda) [*8];
   endproperty
   a_bit_stable: assert property (p_bit_stable)
      else $error("sda moved just after scl rise");

   property p_start_free;
      s_start |-> !d_sda_oe;
   endproperty
   a_start_free: assert property (p_start_free)
      else $error("memory end drove sda at start");

   property p_stop_idle;
      s_stop |=> (scl && sda && !d_sda_oe) [*8];
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("bus not idle after stop");

   property p_frame;
      s_stop |-> bit_no == 4'h1;
   endproperty
   a_frame: assert property (p_frame)
      else $error("transfer not whole nine-clock bytes");

   property p_ack_hold;
      s_rise ##0 d_sda_oe |-> (d_sda_oe && !sda) [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("low drive not held over scl high");

   property p_addr_quiet;
      first && bit_no < 4'h8 |-> !d_sda_oe;
   endproperty
   a_addr_quiet: assert property (p_addr_quiet)
      else $error("memory end drove during address byte");

   property p_noack_free;
      quiet |-> !d_sda_oe;
   endproperty
   a_noack_free: assert property (p_noack_free)
      else $error("memory end drove after missing ack");
endmodule

`default_nettype wire

// *** test/testbench.sv ***
/*
 * testbench: master and memory end joined on one bus; page write, busy
 * probe, address refusal, column wrap, current and long reads.
 * assumes the package constants and a shortened program cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench import eeprom_link_pkg::*;;
   localparam int PROG = 3000;
   logic sys_clk;
   logic nrst;
   logic cmd_valid;
   logic cmd_ready;
   logic [1:0] cmd_kind;
   logic [7:0] cmd_data;
   logic cmd_more;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic rsp_ack;
   logic programming;
   logic [2:0] straps;
   logic [6:0] ptr;
   logic refused;
   logic [7:0] mem [MEM_BYTES];
   logic [8:0] rsp_q [$];
   int mismatches;
   int comparisons;

   two_wire_if bus ();
   eeprom_slave #(.PROG_CYCLES(PROG)) i_eeprom_slave (.sys_clk(sys_clk), .nrst(nrst),
      .bus(bus), .hw_select_pin_0(straps[0]), .hw_select_pin_1(straps[1]),
      .hw_select_pin_2(straps[2]), .programming(programming));
   two_wire_master i_two_wire_master (.sys_clk(sys_clk), .nrst(nrst), .bus(bus),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
      .cmd_data(cmd_data), .cmd_more(cmd_more), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_ack(rsp_ack));
   link_properties i_link_properties (.sys_clk(sys_clk), .nrst(nrst), .scl(bus.scl),
      .sda(bus.sda), .d_sda_oe(bus.d_sda_oe));

   // clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      #(90000 * 50);
      mismatches++;
      finish_test();
   end

   // answers are queued so queued commands never lose one
   always @(posedge sys_clk) begin
      if (rsp_valid === 1'b1) rsp_q.push_back({rsp_ack, rsp_data});
   end

   task automatic finish_test();
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // valid stays up between commands; a full queue shows as refused
   task automatic put(input cmd_kind_t k, input logic [7:0] d, input logic m);
      int n;
      n = 0;
      cmd_kind <= k;
      cmd_data <= d;
      cmd_more <= m;
      cmd_valid <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (cmd_ready !== 1'b1) refused = 1'b1;
      end while (cmd_ready !== 1'b1 && n < 40000);
   endtask

   task automatic rsp(input logic [7:0] d, input logic a);
      int n;
      n = 0;
      while (rsp_q.size() == 0 && n < 40000) begin
         @(posedge sys_clk);
         n++;
      end
      // a missing answer is turned into a certain mismatch
      if (rsp_q.size() == 0) rsp_q.push_back(~{a, d});
      cmp8(rsp_q[0][7:0], d);
      cmp1(rsp_q[0][8], a);
      void'(rsp_q.pop_front());
   endtask

   task automatic settle();
      int n;
      n = 0;
      repeat (400) @(posedge sys_clk);
      while (programming !== 1'b0 && n < 2 * PROG) begin
         @(posedge sys_clk);
         n++;
      end
      cmp1(programming, 1'b0);
   endtask

   task automatic wr(input logic [6:0] wa, input int n, input logic [7:0] base);
      put(CMD_START, 8'h00, 1'b0);
      put(CMD_WRITE, {SLAVE_GROUP, straps, 1'b0}, 1'b0);
      put(CMD_WRITE, {1'b0, wa}, 1'b0);
      for (int i = 0; i < n; i++) put(CMD_WRITE, base + 8'(i), 1'b0);
      put(CMD_STOP, 8'h00, 1'b0);
      cmd_valid <= 1'b0;
      rsp({SLAVE_GROUP, straps, 1'b0}, 1'b1);
      rsp({1'b0, wa}, 1'b1);
      for (int i = 0; i < n; i++) begin
         rsp(base + 8'(i), 1'b1);
         mem[{wa[6:3], wa[2:0] + 3'(i)}] = base + 8'(i);
      end
      ptr = wa + 7'(n);
   endtask

   // own address while the row is still being programmed
   task automatic busy_probe();
      put(CMD_START, 8'h00, 1'b0);
      put(CMD_WRITE, {SLAVE_GROUP, straps, 1'b0}, 1'b0);
      put(CMD_STOP, 8'h00, 1'b0);
      cmd_valid <= 1'b0;
      rsp({SLAVE_GROUP, straps, 1'b0}, 1'b0);
      cmp1(programming, 1'b1);
   endtask

   // foreign address, then a byte that must stay unanswered
   task automatic refuse();
      put(CMD_START, 8'h00, 1'b0);
      put(CMD_WRITE, {SLAVE_GROUP, ~straps, 1'b0}, 1'b0);
      put(CMD_WRITE, 8'h00, 1'b0);
      put(CMD_STOP, 8'h00, 1'b0);
      cmd_valid <= 1'b0;
      rsp({SLAVE_GROUP, ~straps, 1'b0}, 1'b0);
      rsp(8'h00, 1'b0);
   endtask

   task automatic rd_cur();
      put(CMD_START, 8'h00, 1'b0);
      put(CMD_WRITE, {SLAVE_GROUP, straps, 1'b1}, 1'b0);
      put(CMD_READ, 8'h00, 1'b0);
      put(CMD_STOP, 8'h00, 1'b0);
      cmd_valid <= 1'b0;
      rsp({SLAVE_GROUP, straps, 1'b1}, 1'b1);
      rsp(mem[ptr], 1'b0);
   endtask

   // more commands than the queue holds, so the master stalls the feed
   task automatic rd_seq(input logic [6:0] wa, input int n);
      refused = 1'b0;
      put(CMD_START, 8'h00, 1'b0);
      put(CMD_WRITE, {SLAVE_GROUP, straps, 1'b0}, 1'b0);
      put(CMD_WRITE, {1'b0, wa}, 1'b0);
      put(CMD_START, 8'h00, 1'b0);
      put(CMD_WRITE, {SLAVE_GROUP, straps, 1'b1}, 1'b0);
      for (int i = 0; i < n; i++) put(CMD_READ, 8'h00, i < n - 1);
      put(CMD_STOP, 8'h00, 1'b0);
      cmd_valid <= 1'b0;
      rsp({SLAVE_GROUP, straps, 1'b0}, 1'b1);
      rsp({1'b0, wa}, 1'b1);
      rsp({SLAVE_GROUP, straps, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) rsp(mem[wa + 7'(i)], i < n - 1);
      cmp1(refused, 1'b1);
   endtask

   initial begin
      nrst = 1'b0;
      cmd_valid = 1'b0;
      cmd_kind = 2'h0;
      cmd_data = 8'h00;
      cmd_more = 1'b0;
      straps = 3'h5;
      ptr = 7'h00;
      refused = 1'b0;
      foreach (mem[i]) mem[i] = ERASED_BYTE;
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (8) @(posedge sys_clk);
      cmp1(bus.scl & bus.sda, 1'b1);
      wr(7'h10, 8, 8'h40);
      busy_probe();
      settle();
      refuse();
      wr(7'h0d, 5, 8'h90);
      settle();
      rd_cur();
      rd_seq(7'h0c, 12);
      finish_test();
   end
endmodule

`default_nettype wire
